// File: rtl/nvsc_map.vh
/*
  Constants for the nonvolatile memory host controller: widths, command codes
  and timing counts at a 100 MHz clock.
  Assumes it is included by its bare name from the rtl/ files.
*/
`ifndef NVSC_MAP_VH
`define NVSC_MAP_VH

// Clock rate
`define NVSC_CLK_MHZ         100
// Widths
`define NVSC_ADDR_W          13
`define NVSC_DATA_W          8
`define NVSC_DEPTH           8192
// Command codes
`define NVSC_CMD_READ        2'h0
`define NVSC_CMD_WRITE       2'h1
`define NVSC_CMD_SAVE        2'h2
`define NVSC_CMD_RESTORE     2'h3
// Times as printed
`define NVSC_T_SETUP_NS      5
`define NVSC_T_ACCESS_NS     45
`define NVSC_T_WPULSE_NS     35
`define NVSC_T_INIT_NS       25
`define NVSC_T_SAVE_MS       10
`define NVSC_T_RESTORE_US    20
// Cycle counts: least times round up, longest waits are held in full
`define NVSC_CYC_SETUP       ((`NVSC_T_SETUP_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_CYC_ACCESS      ((`NVSC_T_ACCESS_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_CYC_WPULSE      ((`NVSC_T_WPULSE_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_CYC_INIT        ((`NVSC_T_INIT_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_CYC_SAVE        (`NVSC_T_SAVE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_CYC_RESTORE     (`NVSC_T_RESTORE_US * `NVSC_CLK_MHZ)
// Counter width
`define NVSC_CNT_W           24

`endif

// File: rtl/nvsc_timer.v
/*
  Down counter for the controller's phase timing.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "nvsc_map.vh"

module nvsc_timer (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rstn,
  // Control
  input  wire                   load,
  input  wire [`NVSC_CNT_W-1:0] load_value,
  // Status
  output wire                   expired
);

  reg [`NVSC_CNT_W-1:0] count;   // Cycles left

  // Load wins; otherwise count down to zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= {`NVSC_CNT_W{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (count != {`NVSC_CNT_W{1'b0}}) begin
      count <= count - {{(`NVSC_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign expired = (count == {`NVSC_CNT_W{1'b0}}) && !load;

endmodule // nvsc_timer

// File: rtl/nvsc_host.v
/*
  Host controller that drives an asynchronous byte-wide memory with a shadow
  nonvolatile store through its active-low pins: reads, writes, saves and
  restores, one command at a time.
  Assumes the memory pins are wired to this block directly and that the
  memory's inputs and outputs settle within the documented times.
*/
`timescale 1ns/1ps
`include "nvsc_map.vh"

module nvsc_host #(
  parameter SAVE_CYCLES = `NVSC_CYC_SAVE  // Save wait, shortened in simulation
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rstn,
  // User command port
  input  wire                    cmd_valid,
  output wire                    cmd_ready,
  input  wire [1:0]              cmd_op,
  input  wire [`NVSC_ADDR_W-1:0] cmd_addr,
  input  wire [`NVSC_DATA_W-1:0] cmd_wdata,
  output reg                     rsp_valid,
  output reg  [`NVSC_DATA_W-1:0] rsp_rdata,
  output reg                     rsp_error,
  // Supply status
  input  wire                    supply_good,
  // Memory pins
  output reg                     chip_select_n,
  output reg                     output_enable_n,
  output reg                     write_enable_n,
  output reg                     nonvolatile_enable_n,
  output reg  [`NVSC_ADDR_W-1:0] address_bus,
  input  wire [`NVSC_DATA_W-1:0] data_io_bus_in,
  output reg  [`NVSC_DATA_W-1:0] data_io_bus_out,
  output reg                     data_io_bus_oe
);

  // States
  localparam [2:0] ST_IDLE  = 3'h0;  // Pins idle, accepting commands
  localparam [2:0] ST_SETUP = 3'h1;  // Address and mode pins settle
  localparam [2:0] ST_PULSE = 3'h2;  // Access or initiation pulse
  localparam [2:0] ST_WAIT  = 3'h3;  // Transfer runs inside the device
  localparam [2:0] ST_GAP   = 3'h4;  // Recovery with all pins high
  localparam [2:0] ST_DONE  = 3'h5;  // Answer cycle

  reg  [2:0]              state;       // Current state
  reg  [1:0]              op;          // Command in progress
  reg                     load;        // Timer load strobe
  reg  [`NVSC_CNT_W-1:0]  load_value;  // Timer load value
  reg                     aborted;     // Save lost to supply drop
  wire                    expired;     // Timer done

  // Cycle count as a counter-width value
  function [`NVSC_CNT_W-1:0] cyc;
    input integer n;
    begin
      cyc = n[`NVSC_CNT_W-1:0];
    end
  endfunction

  nvsc_timer u_timer (
    .clk        (clk),
    .rstn       (rstn),
    .load       (load),
    .load_value (load_value),
    .expired    (expired)
  );

  // Commands are taken only while the sequencer is idle
  assign cmd_ready = (state == ST_IDLE);

  // Sequencer for all pin cycles
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state                <= ST_IDLE;
      op                   <= `NVSC_CMD_READ;
      load                 <= 1'b0;
      load_value           <= {`NVSC_CNT_W{1'b0}};
      aborted              <= 1'b0;
      rsp_valid            <= 1'b0;
      rsp_rdata            <= {`NVSC_DATA_W{1'b0}};
      rsp_error            <= 1'b0;
      chip_select_n        <= 1'b1;
      output_enable_n      <= 1'b1;
      write_enable_n       <= 1'b1;
      nonvolatile_enable_n <= 1'b1;
      address_bus          <= {`NVSC_ADDR_W{1'b0}};
      data_io_bus_out      <= {`NVSC_DATA_W{1'b0}};
      data_io_bus_oe       <= 1'b0;
    end else begin
      load      <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Address settles before chip select and the read or write strobe; save and restore set their mode pins with it
          if (cmd_valid) begin
            op         <= cmd_op;
            aborted    <= 1'b0;
            address_bus <= cmd_addr;
            load       <= 1'b1;
            load_value <= cyc(`NVSC_CYC_SETUP);
            state      <= ST_SETUP;
            case (cmd_op)
              `NVSC_CMD_WRITE: begin
                data_io_bus_out <= cmd_wdata;
                data_io_bus_oe  <= 1'b1;
                nonvolatile_enable_n <= 1'b1;
              end
              `NVSC_CMD_SAVE: begin
                // Enable and write enable first, select starts it
                nonvolatile_enable_n <= 1'b0;
                write_enable_n       <= 1'b0;
                output_enable_n      <= 1'b1;
              end
              `NVSC_CMD_RESTORE: begin
                nonvolatile_enable_n <= 1'b0;
                output_enable_n      <= 1'b0;
                write_enable_n       <= 1'b1;
              end
              default: begin
                nonvolatile_enable_n <= 1'b1;
              end
            endcase
          end
        end
        ST_SETUP: begin
          // Chip select is the last edge for save and restore; reads and writes drop their strobe with it
          if (expired) begin
            chip_select_n <= 1'b0;
            load          <= 1'b1;
            state         <= ST_PULSE;
            case (op)
              `NVSC_CMD_WRITE: begin
                write_enable_n <= 1'b0;
                load_value     <= cyc(`NVSC_CYC_WPULSE);
              end
              `NVSC_CMD_READ: begin
                output_enable_n <= 1'b0;
                load_value      <= cyc(`NVSC_CYC_ACCESS);
              end
              default: begin
                load_value <= cyc(`NVSC_CYC_INIT);
              end
            endcase
          end
        end
        ST_PULSE: begin
          if (op == `NVSC_CMD_SAVE && !supply_good) begin
            aborted <= 1'b1;
          end
          // Other pins stay static while select is held
          if (expired) begin
            // Ending by select works for both transfers
            chip_select_n   <= 1'b1;
            write_enable_n  <= 1'b1;
            output_enable_n <= 1'b1;
            load            <= 1'b1;
            case (op)
              `NVSC_CMD_READ: begin
                rsp_rdata  <= data_io_bus_in;
                load_value <= cyc(`NVSC_CYC_SETUP);
                state      <= ST_GAP;
              end
              `NVSC_CMD_WRITE: begin
                load_value <= cyc(`NVSC_CYC_SETUP);
                state      <= ST_GAP;
              end
              `NVSC_CMD_SAVE: begin
                load_value <= cyc(SAVE_CYCLES);
                state      <= ST_WAIT;
              end
              default: begin
                load_value <= cyc(`NVSC_CYC_RESTORE);
                state      <= ST_WAIT;
              end
            endcase
          end
        end
        ST_WAIT: begin
          // Device busy; pins held idle so no access is attempted
          nonvolatile_enable_n <= 1'b1;
          if (op == `NVSC_CMD_SAVE && !supply_good) begin
            aborted <= 1'b1;
          end
          if (expired) begin
            load       <= 1'b1;
            load_value <= cyc(`NVSC_CYC_SETUP);
            state      <= ST_GAP;
          end
        end
        ST_GAP: begin
          // Release the data bus after the hold time
          data_io_bus_oe       <= 1'b0;
          nonvolatile_enable_n <= 1'b1;
          if (expired) begin
            rsp_valid <= 1'b1;
            rsp_error <= aborted;
            state     <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // nvsc_host

// File: bench/nvsc_properties.sv
/* Pin assertions for nvsc_host.
   Assumes binding into nvsc_host. */
`timescale 1ns/1ps
module nvsc_props (
  // Clock, reset
  input wire        clk,
  input wire        rstn,
  // Memory pins
  input wire        chip_select_n,
  input wire        output_enable_n,
  input wire        write_enable_n,
  input wire        nonvolatile_enable_n,
  input wire [12:0] address_bus,
  input wire        data_io_bus_oe
);
  // Write, save, restore patterns
  wire wr = !chip_select_n && !write_enable_n && nonvolatile_enable_n;
  wire sv = !chip_select_n && !write_enable_n && !nonvolatile_enable_n && output_enable_n;
  wire rc = !chip_select_n && !output_enable_n && !nonvolatile_enable_n && write_enable_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ahold; wr |-> $stable(address_bus); endproperty
  a_ahold: assert property (p_ahold) else $error("address moved");
  property p_gate; wr |-> output_enable_n && data_io_bus_oe; endproperty
  a_gate: assert property (p_gate) else $error("bus clash");
  property p_sw; $rose(sv) |-> sv [*3]; endproperty
  a_sw: assert property (p_sw) else $error("save short");
  property p_send; $rose(sv) |-> ##[3:8] !sv; endproperty
  a_send: assert property (p_send) else $error("save held");
  property p_sset;
    sv |-> $stable({write_enable_n, output_enable_n, nonvolatile_enable_n});
  endproperty
  a_sset: assert property (p_sset) else $error("save setup");
  property p_rw; $rose(rc) |-> rc [*3]; endproperty
  a_rw: assert property (p_rw) else $error("restore short");
  property p_rwe; rc |=> write_enable_n || chip_select_n; endproperty
  a_rwe: assert property (p_rwe) else $error("restore cut");
  c_wr: cover property ($fell(wr));
  c_sv: cover property ($rose(sv));
  c_rc: cover property ($rose(rc));
endmodule // nvsc_props
bind nvsc_host nvsc_props u_props (.*);

// File: bench/nvsc_dev.sv
/* Behavioural memory with a shadow store.
   Assumes host-driven pin levels; delays in ns. */
`timescale 1ns/1ps
module nvsc_dev #(
  parameter T_SAVE = 300  // Save time in ns
) (
  // Pins and supply
  input  wire        chip_select_n,
  input  wire        output_enable_n,
  input  wire        write_enable_n,
  input  wire        nonvolatile_enable_n,
  input  wire [12:0] address_bus,
  input  wire [7:0]  data_io_bus_in,
  output wire [7:0]  dev_q,
  input  wire        supply_good
);
  reg [7:0] mem [0:8191];  // Working array
  reg [7:0] nv [0:8191];   // Shadow store
  reg       busy = 1'h0;   // Transfer running
  wire wr = !chip_select_n && !write_enable_n && nonvolatile_enable_n;
  wire sv = !chip_select_n && !write_enable_n && !nonvolatile_enable_n && output_enable_n;
  wire rc = !chip_select_n && !output_enable_n && !nonvolatile_enable_n && write_enable_n;
  wire rd = !chip_select_n && !output_enable_n && write_enable_n && nonvolatile_enable_n;
  // Released lines show the inverse, so stale bytes never pass
  assign dev_q = (rd && !busy) ? mem[address_bus] : ~mem[address_bus];
  // Byte lands as the write ends
  always @(negedge wr) if (!busy) mem[address_bus] = data_io_bus_in;
  // Only a fresh entry starts a transfer
  always @(posedge sv or posedge rc) if (!busy && (rc || supply_good)) xfer(sv);
  // Held past the initiation width, it finishes alone
  task xfer(input s);
    begin
      busy = 1'h1;
      #25;
      if (s ? sv : rc) begin
        #(s ? T_SAVE : 15000);
        if (!s) mem = nv;
        else if (supply_good) nv = mem;
      end
      busy = 1'h0;
    end
  endtask
endmodule // nvsc_dev

// File: bench/nvsc_host_tb.sv
/* Bench for nvsc_host against the memory model.
   Assumes rtl/ on the include path. */
`timescale 1ns/1ps
module nvsc_host_tb;
  reg        clk = 1'h0, rstn = 1'h0, cmd_valid = 1'h0, supply_good = 1'h1;
  reg [1:0]  cmd_op = 2'h0;
  reg [12:0] cmd_addr = 13'h0000, a [0:11];
  reg [7:0]  cmd_wdata = 8'h00, rm [0:8191], rn [0:8191];
  reg [16:0] r = 17'h17df6;  // Seed 97782
  integer    compares = 0, mismatches = 0, cyc = 0, i, n;
  wire       cmd_ready, rsp_valid, rsp_error, chip_select_n, output_enable_n;
  wire       write_enable_n, nonvolatile_enable_n, data_io_bus_oe;
  wire [7:0] rsp_rdata, data_io_bus_out, dev_q;
  wire [12:0] address_bus;
  wire [7:0] data_io_bus_in = data_io_bus_oe ? data_io_bus_out : dev_q;
  nvsc_host #(.SAVE_CYCLES(50)) DUT (.*);
  nvsc_dev dev (.*);
  always #5 clk = ~clk;
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out;
    end
  end
  function [16:0] lf(input [16:0] s); lf = {s[15:0], s[16] ^ s[13]}; endfunction
  function [7:0] exp_rd(input [12:0] ad); exp_rd = rm[ad]; endfunction
  // Offer one command, wait for take and answer
  task op(input [1:0] o, input [12:0] ad, input [7:0] d);
    begin
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_op <= o;
      cmd_addr <= ad;
      cmd_wdata <= d;
      n = 0;
      @(posedge clk);
      while (cmd_ready !== 1'h1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      cmd_valid <= 1'h0;
      @(posedge clk);
      while (rsp_valid !== 1'h1 && n < 3000) begin
        n = n + 1;
        @(posedge clk);
      end
      // A command that never answers counts against the run
      if (rsp_valid !== 1'h1) begin
        mismatches++;
        $display("CHECK FAILED answer expected 1 seen %b", rsp_valid);
      end
    end
  endtask
  task chk(input string s, input [7:0] e, g);
    begin
      compares++;
      if (g !== e) begin
        mismatches++;
        $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task wr_all;
    for (i = 0; i < 12; i++) begin
      r = lf(r);
      rm[a[i]] = r[16:9];
      op(2'h1, a[i], r[16:9]);
    end
  endtask
  task rd_all;
    for (i = 0; i < 12; i++) begin
      op(2'h0, a[i], 8'h00);
      chk("read", exp_rd(a[i]), rsp_rdata);
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    // Address ends first, then random picks
    for (i = 0; i < 12; i++) begin
      r = lf(r);
      a[i] = i == 0 ? 13'h0000 : i == 1 ? 13'h1fff : r[12:0];
    end
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    wr_all;
    rd_all;
    $display("test write_read done");
    rn = rm;
    op(2'h2, 13'h0000, 8'h00);
    chk("save error", 8'h00, rsp_error);
    wr_all;
    rd_all;
    op(2'h3, 13'h0000, 8'h00);
    rm = rn;
    rd_all;
    $display("test save_restore done");
    supply_good <= 1'h0;
    wr_all;
    op(2'h2, 13'h0000, 8'h00);
    chk("save error", 8'h01, rsp_error);
    supply_good <= 1'h1;
    op(2'h3, 13'h0000, 8'h00);
    rm = rn;
    rd_all;
    $display("test supply_drop done");
    close_out;
  end
endmodule // nvsc_host_tb
